/* File: logic/ipt_bus_if.sv */
// Eight-bit parallel bus between the timer and its host
`timescale 1ns/100ps
interface ipt_bus_if;
  import ipt_pkg::*;
  logic cs_n;          // Chip select, low active
  logic rd_n;          // Read strobe, low active
  logic wr_n;          // Write strobe, low active
  logic [1:0] addr;    // Address select bits
  logic [7:0] h_dout;  // Host drive value
  logic h_oe;          // Host drives data
  logic [7:0] d_dout;  // Device drive value
  logic d_oe;          // Device drives data
  logic [7:0] data;    // Resolved data bus
  // Wire level from enables, pulled high when idle
  assign data = h_oe ? h_dout : (d_oe ? d_dout : BUS_IDLE);
  modport dev(input cs_n, input rd_n, input wr_n, input addr, input data,
              output d_dout, output d_oe);
  modport host(output cs_n, output rd_n, output wr_n, output addr, output h_dout,
               output h_oe, input data);
endinterface

/* File: logic/ipt_count_elem.sv */
// One counting element, stepped by its own synchronised counter clock
`timescale 1ns/100ps
module ipt_count_elem
  import ipt_pkg::*;
#(
  parameter int W = CNT_W
) (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_cnt_clk,
  input wire logic i_load,
  input wire logic [W-1:0] i_cr,
  input wire logic i_bcd,
  input wire logic i_periodic,
  output logic [W-1:0] o_count,
  output logic o_out,
  output logic o_loaded
);
  localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};

  typedef struct packed {
    logic clk_s1;          // Synchroniser first stage
    logic clk_s2;          // Synchroniser second stage
    logic clk_prev;        // Edge detect history
    logic pend;            // Load waiting for a counter clock edge
    logic [W-1:0] cr_val;  // Whole count captured from the count register
    logic [W-1:0] ce;      // Counting element
    logic out;             // Terminal count output
    logic loaded;          // One-cycle load notice
  } ipt_ce_st_t;

  ipt_ce_st_t q;
  ipt_ce_st_t d;
  logic edge_seen;

  // Down step, binary or four decimal digits
  function automatic logic [W-1:0] dec_count(input logic [W-1:0] v, input logic bcd);
    logic [W-1:0] r;
    logic borrow;
    r = v - ONE;
    borrow = 1'b1;
    if (bcd) begin
      for (int i = 0; i < W / 4; i++) begin
        if (borrow && v[i*4+:4] == 4'h0) begin
          r[i*4+:4] = BCD_DIGIT_MAX;
        end else begin
          r[i*4+:4] = v[i*4+:4] - {3'h0, borrow};
          borrow = 1'b0;
        end
      end
    end
    return r;
  endfunction

  assign edge_seen = q.clk_s2 & ~q.clk_prev;

  // Next state of the counting element
  always_comb begin
    d = q;
    d.loaded = 1'b0;
    d.clk_s1 = i_cnt_clk;
    d.clk_s2 = q.clk_s1;
    d.clk_prev = q.clk_s2;
    // Capture the full count at once
    if (i_load) begin
      d.pend = 1'b1;
      d.cr_val = i_cr;
    end
    if (edge_seen && q.pend) begin
      // Load only from the count register
      d.ce = q.cr_val;
      d.pend = i_load;
      d.out = 1'b0;
      d.loaded = 1'b1;
    end else if (edge_seen) begin
      if (q.ce == ONE) begin
        // Terminal count reached
        d.out = 1'b1;
        d.ce = i_periodic ? q.cr_val : '0;
      end else begin
        d.ce = dec_count(q.ce, i_bcd);
      end
    end
  end

  // State register
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_count = q.ce;
  assign o_out = q.out;
  assign o_loaded = q.loaded;
endmodule

/* File: logic/ipt_pkg.sv */
// Shared constants, types and decoding for the interval timer and its bus host
package ipt_pkg;
  localparam int NUM_CNT = 3;              // Counters in the device
  localparam int CNT_W = 16;               // Counting element width
  localparam logic [1:0] ADDR_CW = 2'h3;   // Control word address
  localparam int CW_SEL_LO = 6;            // Counter select field base
  localparam int CW_FMT_LO = 4;            // Access format field base
  localparam int CW_MODE_LO = 1;           // Mode field base
  localparam int CW_BCD_BIT = 0;           // Decimal counting flag
  localparam logic [1:0] SEL_READBACK = 2'h3;
  localparam logic [1:0] FMT_LATCH = 2'h0; // Counter latch command
  localparam logic [1:0] FMT_LO = 2'h1;    // Low byte only
  localparam logic [1:0] FMT_HI = 2'h2;    // High byte only
  localparam logic [1:0] FMT_LOHI = 2'h3;  // Low then high byte
  localparam int MODE_DC_BIT = 2;          // Ignored top bit for modes 2 and 3
  localparam int MODE_PERIODIC_BIT = 1;    // Set for modes 2 and 3
  localparam int RB_COUNT_N_BIT = 5;       // Read-back: low latches count
  localparam int RB_STATUS_N_BIT = 4;      // Read-back: low latches status
  localparam int RB_CNT0_BIT = 1;          // Read-back: counter 0 select
  localparam int ST_OUT_BIT = 7;           // Status: output pin
  localparam int ST_NULL_BIT = 6;          // Status: null count
  localparam int ST_CW_W = 6;              // Status: low control word bits
  localparam logic [7:0] BUS_IDLE = 8'hff; // Undriven data bus level
  localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
  // Host command port
  localparam int AXI_AW = 4;
  localparam logic [AXI_AW-1:0] REG_CMD = 4'h0;
  localparam logic [AXI_AW-1:0] REG_STAT = 4'h4;
  localparam int CMD_ADDR_LO = 8;
  localparam int CMD_READ_BIT = 10;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RDATA_LO = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int HOST_SETUP_CYC = 2;       // Address and select before strobe
  localparam int HOST_STROBE_CYC = 8;      // Strobe low time
  localparam int HOST_HOLD_CYC = 4;        // Address held after strobe
  localparam int HOST_CNT_W = 4;
  typedef enum logic [3:0] {
    H_IDLE = 4'h1,
    H_SETUP = 4'h2,
    H_STROBE = 4'h4,
    H_HOLD = 4'h8
  } ipt_hphase_t;
  // Modes 2 and 3 ignore the top mode bit
  function automatic logic [2:0] ipt_mode_norm(input logic [2:0] m);
    ipt_mode_norm = m;
    if (m[MODE_PERIODIC_BIT]) begin
      ipt_mode_norm[MODE_DC_BIT] = 1'b0;
    end
  endfunction
endpackage

/* File: logic/ipt_timer_dev.sv */
// Timer device: bus decode, control words, count and output latches
//
// Operation
// - Write at address three stores control word
// - Control word cannot be read back
// - Three independent counters, own configuration each
// - Sixteen-bit down counter, loaded from count register
// - Output latch tracks, holds latched count until read
// - Reads return output latch, one byte each
// - Count writes fill count register bytewise
// - Both count bytes move to element together
// - Single-byte format clears the other byte
// - Power-up state of counters is undefined; here reset zeroes them
// - Host writes control word before count
// - Counts go to counter address, given format
// - Host supplies count in configured byte format
// - Control word fields: select, format, mode, decimal
// - Select codes pick counters; three means read-back
// - Format: latch, low, high, low then high
// - Modes two, three ignore top mode bit
// - Bit zero picks binary or decimal counting
// - Status holds control word, output, null flag
// - Address bits pick counter or control word
// - Strobes ignored unless chip select low
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/100ps
module ipt_timer_dev
  import ipt_pkg::*;
(
  ipt_bus_if.dev bus,
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic [NUM_CNT-1:0] i_cnt_clk,
  output logic [NUM_CNT-1:0] o_cnt_out
);
  // Per-counter programming state
  typedef struct packed {
    logic [7:0] cw;        // Last control word
    logic wr_hi;           // Write pointer at high byte
    logic rd_hi;           // Read pointer at high byte
    logic [15:0] cr;       // Count register
    logic load;            // Load request pulse
    logic cnt_lat;         // Output latch holding
    logic [15:0] ol;       // Output latch
    logic st_lat;          // Status latched
    logic [7:0] st;        // Latched status byte
    logic null_cnt;        // Count written, not yet loaded
  } ipt_chan_t;

  typedef struct packed {
    logic cs_s1;           // Pin synchronisers
    logic cs_s2;
    logic rd_s1;
    logic rd_s2;
    logic wr_s1;
    logic wr_s2;
    logic [1:0] addr_s1;
    logic [1:0] addr_s2;
    logic [7:0] dat_s1;
    logic [7:0] dat_s2;
    logic wr_act;          // Qualified write seen last cycle
    logic rd_act;          // Qualified read seen last cycle
    logic [7:0] wdat;      // Data seen during the write
    logic [7:0] dout;      // Read data driver
    logic oe;              // Read data enable
    ipt_chan_t [NUM_CNT-1:0] ch;
  } ipt_dev_st_t;

  ipt_dev_st_t q;
  ipt_dev_st_t d;
  logic [CNT_W-1:0] ce_count [NUM_CNT];
  logic [NUM_CNT-1:0] ce_out;
  logic [NUM_CNT-1:0] ce_loaded;
  logic wr_now;
  logic rd_now;
  logic wr_done;
  logic rd_done;
  logic [1:0] sel;
  logic [1:0] fmt;

  // Byte a read returns for one counter
  function automatic logic [7:0] rd_byte(input ipt_chan_t c);
    logic [1:0] f;
    f = c.cw[CW_FMT_LO+:2];
    if (c.st_lat) begin
      rd_byte = c.st;
    end else if (f == FMT_HI || (f == FMT_LOHI && c.rd_hi)) begin
      rd_byte = c.ol[15:8];
    end else begin
      rd_byte = c.ol[7:0];
    end
  endfunction

  // Strobes qualified by chip select
  assign wr_now = ~q.cs_s2 & ~q.wr_s2;
  assign rd_now = ~q.cs_s2 & ~q.rd_s2;
  assign wr_done = q.wr_act & ~wr_now;
  assign rd_done = q.rd_act & ~rd_now;
  // Control word fields
  assign sel = q.wdat[CW_SEL_LO+:2];
  assign fmt = q.wdat[CW_FMT_LO+:2];

  // Next state of the bus and programming logic
  always_comb begin
    d = q;
    // Pins pass two flip-flops first
    d.cs_s1 = bus.cs_n;
    d.cs_s2 = q.cs_s1;
    d.rd_s1 = bus.rd_n;
    d.rd_s2 = q.rd_s1;
    d.wr_s1 = bus.wr_n;
    d.wr_s2 = q.wr_s1;
    d.addr_s1 = bus.addr;
    d.addr_s2 = q.addr_s1;
    d.dat_s1 = bus.data;
    d.dat_s2 = q.dat_s1;
    d.wr_act = wr_now;
    d.rd_act = rd_now;
    if (wr_now) begin
      d.wdat = q.dat_s2;
    end
    // Control word address is never driven
    d.oe = rd_now && q.addr_s2 != ADDR_CW;
    d.dout = q.dout;
    for (int i = 0; i < NUM_CNT; i++) begin
      d.ch[i].load = 1'b0;
      // Latch follows the element unless holding
      if (!q.ch[i].cnt_lat) begin
        d.ch[i].ol = ce_count[i];
      end
      if (ce_loaded[i]) begin
        d.ch[i].null_cnt = 1'b0;
      end
      // Read data from the addressed counter
      if (rd_now && q.addr_s2 == 2'(i)) begin
        d.dout = rd_byte(q.ch[i]);
      end
      // End of a read advances the read side
      if (rd_done && q.addr_s2 == 2'(i)) begin
        if (q.ch[i].st_lat) begin
          d.ch[i].st_lat = 1'b0;
        end else if (q.ch[i].cw[CW_FMT_LO+:2] == FMT_LOHI && !q.ch[i].rd_hi) begin
          d.ch[i].rd_hi = 1'b1;
        end else begin
          d.ch[i].rd_hi = 1'b0;
          d.ch[i].cnt_lat = 1'b0;
        end
      end
      // Count byte written to the counter address
      if (wr_done && q.addr_s2 == 2'(i)) begin
        // Format from this counter's last control word
        unique case (q.ch[i].cw[CW_FMT_LO+:2])
          FMT_LO: begin
            d.ch[i].cr = {8'h00, q.wdat};
            d.ch[i].load = 1'b1;
          end
          FMT_HI: begin
            d.ch[i].cr = {q.wdat, 8'h00};
            d.ch[i].load = 1'b1;
          end
          FMT_LOHI: begin
            if (!q.ch[i].wr_hi) begin
              d.ch[i].cr[7:0] = q.wdat;
              d.ch[i].wr_hi = 1'b1;
            end else begin
              d.ch[i].cr[15:8] = q.wdat;
              d.ch[i].wr_hi = 1'b0;
              d.ch[i].load = 1'b1;
            end
          end
          FMT_LATCH: begin
            // Never programmed: count write dropped
            d.ch[i].load = 1'b0;
          end
        endcase
        // Set wins over the load clear
        if (d.ch[i].load) begin
          d.ch[i].null_cnt = 1'b1;
        end
      end
      // Control word address write
      if (wr_done && q.addr_s2 == ADDR_CW) begin
        if (sel == SEL_READBACK) begin
          // Read-back over selected counters
          if (q.wdat[RB_CNT0_BIT+i]) begin
            if (!q.wdat[RB_COUNT_N_BIT] && !q.ch[i].cnt_lat) begin
              d.ch[i].cnt_lat = 1'b1;
              d.ch[i].ol = ce_count[i];
            end
            if (!q.wdat[RB_STATUS_N_BIT] && !q.ch[i].st_lat) begin
              d.ch[i].st_lat = 1'b1;
              d.ch[i].st = {ce_out[i], q.ch[i].null_cnt, q.ch[i].cw[ST_CW_W-1:0]};
            end
          end
        end else if (sel == 2'(i)) begin
          if (fmt == FMT_LATCH) begin
            // Latch command; a second one before read is ignored
            if (!q.ch[i].cnt_lat) begin
              d.ch[i].cnt_lat = 1'b1;
              d.ch[i].ol = ce_count[i];
            end
          end else begin
            d.ch[i].cw = q.wdat;
            d.ch[i].wr_hi = 1'b0;
            d.ch[i].rd_hi = 1'b0;
            d.ch[i].cnt_lat = 1'b0;
            d.ch[i].st_lat = 1'b0;
            d.ch[i].null_cnt = 1'b1;
          end
        end
      end
    end
  end

  // State register; counters start unprogrammed, zeroed for determinism
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      q <= '0;
      q.cs_s1 <= 1'b1;
      q.cs_s2 <= 1'b1;
      q.rd_s1 <= 1'b1;
      q.rd_s2 <= 1'b1;
      q.wr_s1 <= 1'b1;
      q.wr_s2 <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Three identical counting elements
  for (genvar g = 0; g < NUM_CNT; g++) begin : g_cnt
    logic [2:0] mode_n;
    // Normalised mode; top bit dropped for modes 2 and 3
    assign mode_n = ipt_mode_norm(q.ch[g].cw[CW_MODE_LO+:3]);
    ipt_count_elem #(
      .W(CNT_W)
    ) u_ce (
      .i_sys_clk(i_sys_clk),
      .i_srst(i_srst),
      .i_cnt_clk(i_cnt_clk[g]),
      .i_load(q.ch[g].load),
      .i_cr(q.ch[g].cr),
      .i_bcd(q.ch[g].cw[CW_BCD_BIT]),
      .i_periodic(mode_n[MODE_PERIODIC_BIT]),
      .o_count(ce_count[g]),
      .o_out(ce_out[g]),
      .o_loaded(ce_loaded[g])
    );
  end

  assign bus.d_dout = q.dout;
  assign bus.d_oe = q.oe;
  assign o_cnt_out = ce_out;
endmodule

/* File: logic/ipt_timer_host.sv */
// Bus host: AXI4-Lite command registers driving timer bus cycles
`timescale 1ns/100ps
module ipt_timer_host
  import ipt_pkg::*;
#(
  parameter int SETUP_CYC = HOST_SETUP_CYC,
  parameter int STROBE_CYC = HOST_STROBE_CYC,
  parameter int HOLD_CYC = HOST_HOLD_CYC
) (
  ipt_bus_if.host bus,
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic [AXI_AW-1:0] i_axi_awaddr,
  input wire logic i_axi_awvalid,
  output logic o_axi_awready,
  input wire logic [31:0] i_axi_wdata,
  input wire logic [3:0] i_axi_wstrb,
  input wire logic i_axi_wvalid,
  output logic o_axi_wready,
  output logic o_axi_bvalid,
  output logic [1:0] o_axi_bresp,
  input wire logic i_axi_bready,
  input wire logic [AXI_AW-1:0] i_axi_araddr,
  input wire logic i_axi_arvalid,
  output logic o_axi_arready,
  output logic o_axi_rvalid,
  output logic [31:0] o_axi_rdata,
  output logic [1:0] o_axi_rresp,
  input wire logic i_axi_rready
);
  typedef struct packed {
    ipt_hphase_t phase;           // Bus cycle phase
    logic [HOST_CNT_W-1:0] cnt;   // Phase cycles left
    logic [1:0] c_addr;           // Command address bits
    logic [7:0] c_data;           // Command write byte
    logic c_read;                 // Command is a read
    logic [7:0] rbyte;            // Last byte read
    logic [7:0] dat_s1;           // Data pin synchroniser
    logic [7:0] dat_s2;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic h_oe;
    logic aw_got;                 // Write address held
    logic [AXI_AW-1:0] awaddr;
    logic w_got;                  // Write data held
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ipt_host_st_t;

  ipt_host_st_t q;
  ipt_host_st_t d;

  assign o_axi_awready = ~q.aw_got & ~q.bvalid;
  assign o_axi_wready = ~q.w_got & ~q.bvalid;
  assign o_axi_arready = ~q.rvalid;

  // Next state of command port and bus sequencer
  always_comb begin
    d = q;
    d.dat_s1 = bus.data;
    d.dat_s2 = q.dat_s1;
    // Address and data taken in either order
    if (i_axi_awvalid && o_axi_awready) begin
      d.aw_got = 1'b1;
      d.awaddr = i_axi_awaddr;
    end
    if (i_axi_wvalid && o_axi_wready) begin
      d.w_got = 1'b1;
      d.wdata = i_axi_wdata;
      d.wstrb = i_axi_wstrb;
    end
    if (q.bvalid && i_axi_bready) begin
      d.bvalid = 1'b0;
    end
    // Both halves present: perform the write
    if (q.aw_got && q.w_got) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      if (q.awaddr == REG_CMD) begin
        // Start a cycle when idle and both low lanes written
        if (q.phase == H_IDLE && q.wstrb[1:0] == 2'h3) begin
          d.c_data = q.wdata[7:0];
          d.c_addr = q.wdata[CMD_ADDR_LO+:2];
          d.c_read = q.wdata[CMD_READ_BIT];
          d.phase = H_SETUP;
          d.cnt = HOST_CNT_W'(SETUP_CYC - 1);
          d.cs_n = 1'b0;
          d.h_oe = ~q.wdata[CMD_READ_BIT];
        end
      end else if (q.awaddr != REG_STAT) begin
        d.bresp = RESP_SLVERR;
      end
    end
    // Register reads
    if (q.rvalid && i_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (i_axi_arvalid && o_axi_arready) begin
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      d.rdata = '0;
      if (i_axi_araddr == REG_CMD) begin
        d.rdata[7:0] = q.c_data;
        d.rdata[CMD_ADDR_LO+:2] = q.c_addr;
        d.rdata[CMD_READ_BIT] = q.c_read;
      end else if (i_axi_araddr == REG_STAT) begin
        d.rdata[STAT_BUSY_BIT] = q.phase != H_IDLE;
        d.rdata[STAT_RDATA_LO+:8] = q.rbyte;
      end else begin
        d.rresp = RESP_SLVERR;
      end
    end
    // Bus cycle: setup, strobe, hold
    unique case (q.phase)
      H_IDLE: begin
        // Counter preset by the command write, left alone here
      end
      H_SETUP: begin
        d.cnt = q.cnt - 1'b1;
        if (q.cnt == '0) begin
          d.phase = H_STROBE;
          d.cnt = HOST_CNT_W'(STROBE_CYC - 1);
          d.rd_n = ~q.c_read;
          d.wr_n = q.c_read;
        end
      end
      H_STROBE: begin
        d.cnt = q.cnt - 1'b1;
        if (q.cnt == '0) begin
          if (q.c_read) begin
            d.rbyte = q.dat_s2;
          end
          d.phase = H_HOLD;
          d.cnt = HOST_CNT_W'(HOLD_CYC - 1);
          d.rd_n = 1'b1;
          d.wr_n = 1'b1;
        end
      end
      H_HOLD: begin
        d.cnt = q.cnt - 1'b1;
        if (q.cnt == '0) begin
          d.phase = H_IDLE;
          d.cs_n = 1'b1;
          d.h_oe = 1'b0;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      q <= '0;
      q.phase <= H_IDLE;
      q.cs_n <= 1'b1;
      q.rd_n <= 1'b1;
      q.wr_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign bus.cs_n = q.cs_n;
  assign bus.rd_n = q.rd_n;
  assign bus.wr_n = q.wr_n;
  assign bus.addr = q.c_addr;
  assign bus.h_dout = q.c_data;
  assign bus.h_oe = q.h_oe;
  assign o_axi_bvalid = q.bvalid;
  assign o_axi_bresp = q.bresp;
  assign o_axi_rvalid = q.rvalid;
  assign o_axi_rdata = q.rdata;
  assign o_axi_rresp = q.rresp;
endmodule

/* File: sim/ipt_bus_sva.sv */
// Assertions on the parallel bus between timer host and device
`timescale 1ns/100ps
module ipt_bus_sva
  import ipt_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_h_dout,
  input wire logic i_h_oe,
  input wire logic [7:0] i_d_dout,
  input wire logic i_d_oe,
  input wire logic [7:0] i_data
);
  // One clock domain, reset masks all checks
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_srst);
  strobe_select_a: assert property ((!i_rd_n || !i_wr_n) |-> !i_cs_n)
    else $error("strobe active without chip select");
  strobe_excl_a: assert property (i_rd_n || i_wr_n)
    else $error("read and write strobes together");
  write_drive_a: assert property (!i_wr_n |-> i_h_oe && i_data == i_h_dout)
    else $error("write byte not on bus");
  write_width_a: assert property ($fell(i_wr_n) |-> !i_wr_n [*5])
    else $error("write strobe too short");
  read_float_a: assert property (!i_rd_n |-> !i_h_oe)
    else $error("host drives bus during read");
  cw_noread_a: assert property ((!i_cs_n && i_addr == ADDR_CW) |-> !i_d_oe)
    else $error("device drives at control word address");
  dev_answer_a: assert property ($rose(i_d_oe) |-> !i_cs_n && !i_rd_n)
    else $error("device drives without read");
  dev_release_a: assert property ($rose(i_rd_n) |-> ##[1:5] !i_d_oe)
    else $error("device keeps bus after read");
  addr_steady_a: assert property ((!i_cs_n && !$past(i_cs_n)) |-> $stable(i_addr))
    else $error("address moved within a bus cycle");
  bus_fight_a: assert property (!(i_h_oe && i_d_oe))
    else $error("both ends drive the bus");
  dev_read_c: cover property ($rose(i_d_oe));
endmodule

/* File: sim/tb.sv */
// Testbench joining timer host and device over the parallel bus
`timescale 1ns/100ps
`define CHK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", what, exp, got); end end
module tb;
  import ipt_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [NUM_CNT-1:0] cclk = '0;  // Counter clock pins
  logic [NUM_CNT-1:0] cnt_out;
  logic [AXI_AW-1:0] awaddr = '0;
  logic [AXI_AW-1:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, bexp;
  logic [31:0] rdata, last_rd;
  logic [65:0] rn;            // Read note: response, mask, value
  logic [1:0] bq[$];          // Expected write responses
  logic [65:0] rq[$];         // Expected read notes
  logic [31:0] rs = 32'hf7e9; // Random state
  logic [15:0] cv;            // Expected count
  int error_cnt = 0;
  int checks_done = 0;
  ipt_bus_if ipt_bus_if_i();
  ipt_timer_dev ipt_timer_dev_i (.bus(ipt_bus_if_i.dev), .i_sys_clk(i_sys_clk),
    .i_srst(i_srst), .i_cnt_clk(cclk), .o_cnt_out(cnt_out));
  ipt_timer_host ipt_timer_host_i (.bus(ipt_bus_if_i.host), .i_sys_clk(i_sys_clk),
    .i_srst(i_srst), .i_axi_awaddr(awaddr), .i_axi_awvalid(awvalid),
    .o_axi_awready(awready), .i_axi_wdata(wdata), .i_axi_wstrb(4'hf),
    .i_axi_wvalid(wvalid), .o_axi_wready(wready), .o_axi_bvalid(bvalid),
    .o_axi_bresp(bresp), .i_axi_bready(bready), .i_axi_araddr(araddr),
    .i_axi_arvalid(arvalid), .o_axi_arready(arready), .o_axi_rvalid(rvalid),
    .o_axi_rdata(rdata), .o_axi_rresp(rresp), .i_axi_rready(rready));
  ipt_bus_sva ipt_bus_sva_i (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
    .i_cs_n(ipt_bus_if_i.cs_n), .i_rd_n(ipt_bus_if_i.rd_n), .i_wr_n(ipt_bus_if_i.wr_n),
    .i_addr(ipt_bus_if_i.addr), .i_h_dout(ipt_bus_if_i.h_dout),
    .i_h_oe(ipt_bus_if_i.h_oe), .i_d_dout(ipt_bus_if_i.d_dout), .i_d_oe(ipt_bus_if_i.d_oe),
    .i_data(ipt_bus_if_i.data));
  // Clock
  always #25 i_sys_clk = ~i_sys_clk;
  // Xorshift step
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  // AXI write, response noted for the monitor
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    logic pa;
    logic pw;
    @(posedge i_sys_clk);
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw) begin
      @(posedge i_sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      pa = pa && !awready;
      pw = pw && !wready;
    end
    while (!bvalid) @(posedge i_sys_clk);
    bready <= 1'b0;
  endtask
  // AXI read, masked expectation noted for the monitor
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] v,
      input logic [1:0] r);
    @(posedge i_sys_clk);
    rq.push_back({r, m, v});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge i_sys_clk);
    while (!arready) @(posedge i_sys_clk);
    arvalid <= 1'b0;
    @(posedge i_sys_clk);
    while (!rvalid) @(posedge i_sys_clk);
    last_rd = rdata;
    rready <= 1'b0;
  endtask
  // Wait until the bus cycle has finished
  task automatic poll();
    last_rd = 32'h1;
    while (last_rd[STAT_BUSY_BIT] !== 1'b0) axi_rd(REG_STAT, 32'h0, 32'h0, RESP_OKAY);
  endtask
  task automatic dev_op(input logic rd, input logic [1:0] a, input logic [7:0] b);
    axi_wr(REG_CMD, {21'h0, rd, a, b}, RESP_OKAY);
    poll();
  endtask
  task automatic dev_rd(input logic [1:0] a, input logic [7:0] e);
    dev_op(1'b1, a, 8'h00);
    axi_rd(REG_STAT, 32'hff00, {16'h0, e, 8'h00}, RESP_OKAY);
  endtask
  // Counter clock pulses, high and low three cycles each
  task automatic cpulse(input int c, input int n);
    repeat (n) begin
      repeat (3) @(posedge i_sys_clk);
      cclk[c] <= 1'b1;
      repeat (3) @(posedge i_sys_clk);
      cclk[c] <= 1'b0;
    end
    repeat (4) @(posedge i_sys_clk);
  endtask
  // Monitor: compare each answer with the oldest note
  always @(posedge i_sys_clk) begin
    if (bvalid && bready) begin
      bexp = bq.pop_front();
      `CHK("bresp", bexp, bresp)
    end
    if (rvalid && rready) begin
      rn = rq.pop_front();
      `CHK("rresp", rn[65:64], rresp)
      if (rn[63:32] != 32'h0) `CHK("rdata", rn[31:0], rdata & rn[63:32])
    end
  end
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (40000) @(posedge i_sys_clk);
    error_cnt++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    axi_wr(4'h8, 32'h0, RESP_SLVERR);
    axi_rd(4'h8, 32'hffffffff, 32'h0, RESP_SLVERR);
    axi_wr(REG_STAT, 32'h0, RESP_OKAY);
    axi_wr(REG_CMD, {21'h0, 1'b1, ADDR_CW, 8'h5a}, RESP_OKAY);
    axi_rd(REG_CMD, 32'h7ff, {21'h0, 1'b1, ADDR_CW, 8'h5a}, RESP_OKAY);
    poll();
    axi_rd(REG_STAT, 32'hff00, {16'h0, BUS_IDLE, 8'h00}, RESP_OKAY);
    $display("test register map done");
    rs = xs(rs);
    cv = rs[15:0] | 16'h0100;
    dev_op(1'b0, ADDR_CW, 8'h30);
    dev_op(1'b0, 2'h0, cv[7:0]);
    dev_op(1'b0, 2'h0, cv[15:8]);
    cpulse(0, 1);
    dev_rd(2'h0, cv[7:0]);
    dev_rd(2'h0, cv[15:8]);
    cpulse(0, 3);
    cv = cv - 16'h3;
    dev_op(1'b0, ADDR_CW, 8'h00);
    cpulse(0, 2);
    dev_rd(2'h0, cv[7:0]);
    dev_rd(2'h0, cv[15:8]);
    cv = cv - 16'h2;
    dev_rd(2'h0, cv[7:0]);
    dev_rd(2'h0, cv[15:8]);
    dev_op(1'b0, ADDR_CW, 8'he2);
    dev_rd(2'h0, 8'h30);
    $display("test two-byte count done");
    dev_op(1'b0, ADDR_CW, 8'h71);
    dev_op(1'b0, 2'h1, 8'h00);
    dev_op(1'b0, 2'h1, 8'h10);
    cpulse(1, 2);
    dev_rd(2'h1, 8'h99);
    dev_rd(2'h1, 8'h09);
    $display("test decimal count done");
    for (int f = 1; f <= 2; f++) begin
      dev_op(1'b0, ADDR_CW, {2'h2, f[1:0], 4'h0});
      dev_op(1'b0, 2'h2, 8'h05);
      cpulse(2, 1);
      dev_op(1'b0, ADDR_CW, {2'h2, FMT_LOHI, 4'h0});
      dev_rd(2'h2, (f == 1) ? 8'h05 : 8'h00);
      dev_rd(2'h2, (f == 1) ? 8'h00 : 8'h05);
    end
    $display("test single-byte formats done");
    for (int m = 0; m < 8; m++) begin
      dev_op(1'b0, ADDR_CW, {2'h2, FMT_LO, m[2:0], 1'b0});
      dev_op(1'b0, 2'h2, 8'h02);
      cpulse(2, 3);
      dev_rd(2'h2, m[1] ? 8'h02 : 8'h00);
      `CHK("cnt_out", 1'b1, cnt_out[2])
    end
    // Read-back count latch on counter 2, then release after one read
    dev_op(1'b0, ADDR_CW, 8'hd8);
    cpulse(2, 1);
    dev_rd(2'h2, 8'h02);
    dev_rd(2'h2, 8'h01);
    $display("test mode codes done");
    report_and_stop();
  end
endmodule
